// File: stw_pkg.sv
// Purpose: Shared constants for the two-wire mode of the serial channel.
// Assumes: 8-bit register data, 16-bit read data, 4-bit register index.
// Notes: Offsets are register indices on the plain register port.
package stw_pkg;
  localparam int unsigned ADDR_W = 4;
  // Register offsets
  localparam logic [3:0] OFF_TXBUF = 4'h0, OFF_RXBUF = 4'h1, OFF_BAUD = 4'h2, OFF_MODE = 4'h3;
  localparam logic [3:0] OFF_CTLA = 4'h4, OFF_CTLB = 4'h5, OFF_SPCA = 4'h6, OFF_SPCB = 4'h7;
  localparam logic [3:0] OFF_SPCC = 4'h8, OFF_SPCD = 4'h9;
  // Reset values
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [8:0] RST_SHIFT = 9'h1FF;
  localparam logic [15:0] RST_RDATA = 16'h0000;
  // Mode code of serial_mode_sel for two-wire operation
  localparam logic [2:0] SMD_TWOWIRE = 3'h2;
  // channel_mode fields
  localparam int B_SMD_HI = 2, B_CLK_SOURCE_DIR = 3;
  // channel_control_a fields
  localparam int B_PRE_HI = 1, B_SRE = 3, B_FCOFF = 4;
  // channel_control_b fields
  localparam int B_TXON = 0, B_TXE = 1, B_RXON = 2, B_RXF = 3;
  // special_mode_a fields
  localparam int B_TWI = 0, B_BUSY = 2;
  // special_mode_b fields
  localparam int B_ACKIM = 0, B_CSYNC = 1, B_HOLD9 = 2, B_INIT_ON_START_DETECT = 3, B_FORCE = 4, B_SDAOFF = 5;
  // special_mode_c fields
  localparam int B_CLK_PHASE_SEL = 0, B_DLY_HI = 3, B_DLY_LO = 1, B_STA = 4, B_RSTA = 5, B_STP = 6, B_CSEL = 7;
  // special_mode_d fields
  localparam int B_ACKD = 0, B_HSLVL = 1, B_HSOE = 2;
  // receive_buffer read layout
  localparam int B_OVR = 12;
  // Prescaler divide-by minus one
  localparam logic [7:0] DIV_F1_M1 = 8'h00, DIV_F8_M1 = 8'h07, DIV_F32_M1 = 8'h1F;
  // Transfer unit
  localparam logic [3:0] BITS_DATA = 4'h8, BITS_UNIT = 4'h9, BITS_ZERO = 4'h0;
  localparam logic [2:0] DLY_NONE = 3'h0;
  localparam logic [3:0] DLY_ZERO = 4'h0, DLY_ONE = 4'h1;
  // Condition generator states, Gray in the order listed
  typedef enum logic [2:0] {
    STW_C_IDLE = 3'h0,
    STW_C_STA_A = 3'h1,
    STW_C_STA_B = 3'h3,
    STW_C_RS_A = 3'h2,
    STW_C_RS_B = 3'h6,
    STW_C_STP_A = 3'h7,
    STW_C_STP_B = 3'h5
  } stw_cond_e;
endpackage : stw_pkg

// File: stw_twowire.sv
// Purpose: Two-wire bus mode of the serial channel, master or slave.
// Assumes: Open-drain pins with external pull-ups; one clock at 25 MHz.
// Notes: Read data appear in the cycle after the read strobe.
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/100ps
module stw_twowire #(
  parameter logic [7:0] FC_DIV_M1 = 8'h3F
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic [stw_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic hs_o,
  output logic hs_oe_o,
  output logic ev_cond_o,
  output logic ev_ack_o,
  output logic ev_nack_o
);
  import stw_pkg::*;

  logic [2:0] s_scl, s_sda;
  logic scl_f, sda_f, scl_fp, sda_fp;
  logic next_scl_f, next_sda_f;
  logic [7:0] tx_data, baud, mode, ctla, ctlb, spca, spcb, spcc, spcd;
  logic [7:0] next_tx_data, next_baud, next_mode, next_ctla, next_ctlb;
  logic [7:0] next_spca, next_spcb, next_spcc, next_spcd;
  logic txe, rxf, sre, busy, ovr, xfer, pend, hold9, m_scl_low, d_sda_low, c_sda_low;
  logic next_txe, next_rxf, next_sre, next_busy, next_ovr, next_xfer, next_pend;
  logic next_hold9, next_m_scl_low, next_d_sda_low, next_c_sda_low;
  logic [8:0] shift, next_shift, rbuf, next_rbuf;
  logic [7:0] rx_sh, next_rx_sh, pre, next_pre, brg, next_brg;
  logic [3:0] bitcnt, next_bitcnt, dly, next_dly;
  logic [15:0] next_rdata;
  logic next_scl_oe, next_sda_oe, next_ev_cond, next_ev_ack, next_ev_nack;
  stw_cond_e cst, next_cst;
  logic mode_on, master, armed, late;
  logic scl_rise, scl_fall, start_det, stop_det;
  logic [7:0] div_m1;
  logic src_tick, stretch, half_tick, agree, tog_ok, load_evt;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, a change counts once stages two and three agree
  always_comb begin
    next_scl_f = (s_scl[1] == s_scl[2]) ? s_scl[2] : scl_f;
    next_sda_f = (s_sda[1] == s_sda[2]) ? s_sda[2] : sda_f;
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      s_scl <= 3'h7;
      s_sda <= 3'h7;
      scl_f <= 1'b1;
      sda_f <= 1'b1;
      scl_fp <= 1'b1;
      sda_fp <= 1'b1;
    end else begin
      s_scl <= {s_scl[1:0], scl_i};
      s_sda <= {s_sda[1:0], sda_i};
      scl_f <= next_scl_f;
      sda_f <= next_sda_f;
      scl_fp <= scl_f;
      sda_fp <= sda_f;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoded conditions
  always_comb begin
    mode_on = (mode[B_SMD_HI:0] == SMD_TWOWIRE) && spca[B_TWI];
    master = !mode[B_CLK_SOURCE_DIR];
    scl_rise = scl_f && !scl_fp;
    scl_fall = !scl_f && scl_fp;
    start_det = scl_f && scl_fp && sda_fp && !sda_f;
    stop_det = scl_f && scl_fp && !sda_fp && sda_f;
    // Slave runs the delay counter on the raw clock; prescaler ignored
    div_m1 = DIV_F1_M1;
    if (master) begin
      case (ctla[B_PRE_HI:0])
        2'h1: div_m1 = DIV_F8_M1;
        2'h2: div_m1 = DIV_F32_M1;
        2'h3: div_m1 = FC_DIV_M1;
        default: div_m1 = DIV_F1_M1;
      endcase
    end
    src_tick = (pre == div_m1);
    stretch = master && spcb[B_CSYNC] && !m_scl_low && !scl_f;
    half_tick = src_tick && (brg == RST_REG) && !stretch;
    // Toggle only once the bus shows our own level, so no edge is missed
    agree = (scl_f == !m_scl_low);
    tog_ok = master && xfer && agree && !(m_scl_low && (bitcnt == BITS_UNIT)) && !(m_scl_low && pend);
    armed = mode_on && ctlb[B_TXON] && !txe;
    // Slave arms with tx_on and fresh data, and loads on the clock's falling edge
    load_evt = armed && !xfer && (cst == STW_C_IDLE) && (master ? m_scl_low : scl_fall);
    late = spcb[B_ACKIM] || spcc[B_CLK_PHASE_SEL];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers, condition generator and bit engine
  always_comb begin
    next_tx_data = tx_data;
    next_baud = baud;
    next_mode = mode;
    next_ctla = ctla;
    next_ctlb = ctlb;
    next_spca = spca;
    next_spcb = spcb;
    next_spcc = spcc;
    next_spcd = spcd;
    next_txe = txe;
    next_rxf = rxf;
    next_sre = sre;
    next_busy = busy;
    next_ovr = ovr;
    next_xfer = xfer;
    next_pend = pend;
    next_hold9 = hold9;
    next_m_scl_low = m_scl_low;
    next_d_sda_low = d_sda_low;
    next_c_sda_low = c_sda_low;
    next_shift = shift;
    next_rbuf = rbuf;
    next_rx_sh = rx_sh;
    next_bitcnt = bitcnt;
    next_dly = dly;
    next_cst = cst;
    next_ev_cond = 1'b0;
    next_ev_ack = 1'b0;
    next_ev_nack = 1'b0;
    next_pre = src_tick ? RST_REG : 8'(pre + 8'h01);
    next_rdata = RST_RDATA;
    // Register reads; reading the receive buffer clears rx_full
    if (reg_rd_i) begin
      case (reg_addr_i)
        OFF_RXBUF: begin
          next_rdata = 16'({3'h0, ovr, 3'h0, rbuf});
          next_rxf = 1'b0;
        end
        OFF_BAUD: next_rdata = {8'h00, baud};
        OFF_MODE: next_rdata = {8'h00, mode};
        OFF_CTLA: next_rdata = {8'h00, ctla[7:4], sre, ctla[2:0]};
        OFF_CTLB: next_rdata = {8'h00, ctlb[7:4], rxf, ctlb[2], txe, ctlb[0]};
        OFF_SPCA: next_rdata = {8'h00, spca[7:3], busy, spca[1:0]};
        OFF_SPCB: next_rdata = {8'h00, spcb};
        OFF_SPCC: next_rdata = {8'h00, spcc};
        OFF_SPCD: next_rdata = {8'h00, spcd};
        default: next_rdata = RST_RDATA;
      endcase
    end
    if (!ctlb[B_RXON]) begin
      next_ovr = 1'b0;
    end
    // Baud divider: n+1 source ticks per half period
    if (stretch) begin
      next_brg = baud;
    end else if (src_tick) begin
      next_brg = (brg == RST_REG) ? baud : 8'(brg - 8'h01);
    end else begin
      next_brg = brg;
    end
    // Bus state seen on the lines
    if (start_det) begin
      next_busy = 1'b1;
      next_ev_cond = mode_on;
    end
    if (stop_det) begin
      next_busy = 1'b0;
      next_ev_cond = mode_on;
    end
    // Master conditions, one step per half period
    if (mode_on && master && spcc[B_CSEL] && half_tick && !xfer) begin
      case (cst)
        STW_C_IDLE: begin
          if (spcc[B_STA] || spcc[B_RSTA]) begin
            next_cst = m_scl_low ? STW_C_RS_A : STW_C_STA_A;
            next_c_sda_low = !m_scl_low;
          end else if (spcc[B_STP]) begin
            next_cst = STW_C_STP_A;
            next_c_sda_low = 1'b1;
          end
        end
        STW_C_RS_A: begin
          next_m_scl_low = 1'b0;
          next_cst = STW_C_RS_B;
        end
        STW_C_RS_B: begin
          next_c_sda_low = 1'b1;
          next_cst = STW_C_STA_A;
        end
        STW_C_STA_A: begin
          next_m_scl_low = 1'b1;
          next_cst = STW_C_STA_B;
        end
        STW_C_STA_B: begin
          next_spcc[B_STA] = 1'b0;
          next_spcc[B_RSTA] = 1'b0;
          next_cst = STW_C_IDLE;
        end
        STW_C_STP_A: begin
          next_m_scl_low = 1'b0;
          next_cst = STW_C_STP_B;
        end
        STW_C_STP_B: begin
          next_c_sda_low = 1'b0;
          next_spcc[B_STP] = 1'b0;
          next_cst = STW_C_IDLE;
        end
        default: next_cst = STW_C_IDLE;
      endcase
    end
    // Master clock for data units
    if (half_tick && tog_ok) begin
      next_m_scl_low = !m_scl_low;
    end
    // Load a unit: 8 data bits, MSB first, then the acknowledge bit
    if (load_evt) begin
      next_shift = {tx_data, spcd[B_ACKD]};
      next_txe = 1'b1;
      next_sre = 1'b0;
      next_xfer = 1'b1;
      next_bitcnt = BITS_ZERO;
      next_pend = 1'b1;
      next_c_sda_low = 1'b0;
    end
    // Rising edge of the bus clock samples the data line
    if (xfer && scl_rise) begin
      next_bitcnt = 4'(bitcnt + 4'h1);
      next_rx_sh = {rx_sh[6:0], sda_f};
      if ((bitcnt == 4'(BITS_DATA - 4'h1)) && rxf && ctlb[B_RXON]) begin
        next_ovr = 1'b1;
      end
      if (bitcnt == BITS_DATA) begin
        next_rbuf = {sda_f, rx_sh};
        // Overrun does not hold back the receive event
        // Set wins over a same-cycle read, a lone read still clears
        next_rxf = next_rxf || ctlb[B_RXON];
        if (!late) begin
          next_ev_ack = !sda_f;
          next_ev_nack = sda_f;
        end
      end
    end
    // Falling edge: next bit, or end of the unit after the 9th
    if (xfer && scl_fall && (bitcnt != BITS_ZERO)) begin
      next_pend = 1'b1;
      if (bitcnt == BITS_UNIT) begin
        next_xfer = 1'b0;
        next_sre = 1'b1;
        next_shift = RST_SHIFT;
        next_hold9 = spcb[B_HOLD9];
        if (late) begin
          next_ev_ack = !rbuf[8];
          next_ev_nack = rbuf[8];
        end
      end else begin
        next_shift = {shift[7:0], 1'b1};
      end
    end
    // Delay new data bit after the clock went low
    if (pend) begin
      if (dly == DLY_ZERO) begin
        next_d_sda_low = !shift[8];
        next_pend = 1'b0;
      end else if (src_tick) begin
        next_dly = 4'(dly - DLY_ONE);
      end
    end
    if (next_pend && !pend) begin
      next_dly = (spcc[B_DLY_HI:B_DLY_LO] == DLY_NONE) ? DLY_ZERO : 4'({1'b0, spcc[B_DLY_HI:B_DLY_LO]} + DLY_ONE);
    end
    // Slave restarts its unit on a start condition
    if (mode_on && !master && spcb[B_INIT_ON_START_DETECT] && start_det) begin
      next_xfer = 1'b0;
      next_bitcnt = BITS_ZERO;
      next_shift = RST_SHIFT;
      next_pend = 1'b0;
      next_d_sda_low = 1'b0;
      next_hold9 = 1'b0;
    end
    if (!spcb[B_HOLD9] || !mode_on) begin
      next_hold9 = 1'b0;
    end
    // Writes come last so software data beats a same-cycle load
    if (reg_wr_i) begin
      case (reg_addr_i)
        OFF_TXBUF: begin
          next_tx_data = reg_wdata_i;
          next_txe = 1'b0;
          next_hold9 = 1'b0;
        end
        OFF_BAUD: next_baud = reg_wdata_i;
        OFF_MODE: next_mode = reg_wdata_i;
        OFF_CTLA: next_ctla = reg_wdata_i;
        OFF_CTLB: next_ctlb = reg_wdata_i;
        OFF_SPCA: next_spca = reg_wdata_i;
        OFF_SPCB: next_spcb = reg_wdata_i;
        OFF_SPCC: next_spcc = reg_wdata_i;
        OFF_SPCD: next_spcd = reg_wdata_i;
        default: next_tx_data = tx_data;
      endcase
    end
    // Lines are only pulled low or released
    next_scl_oe = mode_on && (spcb[B_FORCE] || next_hold9 || (master && next_m_scl_low));
    next_sda_oe = mode_on && !spcb[B_SDAOFF] && (next_d_sda_low || next_c_sda_low);
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      tx_data <= RST_REG;
      baud <= RST_REG;
      mode <= RST_REG;
      ctla <= RST_REG;
      ctlb <= RST_REG;
      spca <= RST_REG;
      spcb <= RST_REG;
      spcc <= RST_REG;
      spcd <= RST_REG;
      txe <= 1'b1;
      rxf <= 1'b0;
      sre <= 1'b1;
      busy <= 1'b0;
      ovr <= 1'b0;
      xfer <= 1'b0;
      pend <= 1'b0;
      hold9 <= 1'b0;
      m_scl_low <= 1'b0;
      d_sda_low <= 1'b0;
      c_sda_low <= 1'b0;
      shift <= RST_SHIFT;
      rbuf <= RST_SHIFT;
      rx_sh <= RST_REG;
      pre <= RST_REG;
      brg <= RST_REG;
      bitcnt <= BITS_ZERO;
      dly <= DLY_ZERO;
      cst <= STW_C_IDLE;
      reg_rdata_o <= RST_RDATA;
      scl_oe_o <= 1'b0;
      sda_oe_o <= 1'b0;
      hs_o <= 1'b0;
      hs_oe_o <= 1'b0;
      ev_cond_o <= 1'b0;
      ev_ack_o <= 1'b0;
      ev_nack_o <= 1'b0;
    end else begin
      tx_data <= next_tx_data;
      baud <= next_baud;
      mode <= next_mode;
      ctla <= next_ctla;
      ctlb <= next_ctlb;
      spca <= next_spca;
      spcb <= next_spcb;
      spcc <= next_spcc;
      spcd <= next_spcd;
      txe <= next_txe;
      rxf <= next_rxf;
      sre <= next_sre;
      busy <= next_busy;
      ovr <= next_ovr;
      xfer <= next_xfer;
      pend <= next_pend;
      hold9 <= next_hold9;
      m_scl_low <= next_m_scl_low;
      d_sda_low <= next_d_sda_low;
      c_sda_low <= next_c_sda_low;
      shift <= next_shift;
      rbuf <= next_rbuf;
      rx_sh <= next_rx_sh;
      pre <= next_pre;
      brg <= next_brg;
      bitcnt <= next_bitcnt;
      dly <= next_dly;
      cst <= next_cst;
      reg_rdata_o <= next_rdata;
      scl_oe_o <= next_scl_oe;
      sda_oe_o <= next_sda_oe;
      // Flow control off: pin is a plain output, its select unused
      hs_o <= spcd[B_HSLVL];
      hs_oe_o <= ctla[B_FCOFF] && spcd[B_HSOE];
      ev_cond_o <= next_ev_cond;
      ev_ack_o <= next_ev_ack;
      ev_nack_o <= next_ev_nack;
    end
  end

  // Open-drain pins never drive high
  always_ff @(posedge ref_clk_i) begin
    scl_o <= 1'b0;
    sda_o <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_ninth_fall;
    xfer && scl_fall && (bitcnt == BITS_UNIT) && spcb[B_HOLD9] && mode_on;
  endsequence
  sequence s_ack_rise;
    xfer && scl_rise && (bitcnt == BITS_DATA) && !late;
  endsequence

  a_mode_gate: assert property (!mode_on |=> !sda_oe_o && !scl_oe_o) else $error("lines driven out of mode");
  a_force_low: assert property (mode_on && spcb[B_FORCE] |=> scl_oe_o) else $error("clock not forced low");
  a_sda_off: assert property (mode_on && spcb[B_SDAOFF] |=> !sda_oe_o) else $error("data line not released");
  a_tx_gate: assert property ($rose(xfer) |-> $past(armed)) else $error("unit started without data");
  a_ovr_set: assert property (xfer && scl_rise && (bitcnt == 4'h7) && rxf && ctlb[B_RXON] |=> ovr)
    else $error("overrun missed");
  a_rbuf_ack: assert property (xfer && scl_rise && (bitcnt == BITS_DATA) |=> rbuf[8] == $past(sda_f))
    else $error("ack bit not stored");
  a_hold_ninth: assert property (s_ninth_fall |=> hold9 ##0 (1'b1 ##1 scl_oe_o)) else $error("clock not held");
  a_ack_event: assert property (s_ack_rise |=> ev_ack_o != ev_nack_o) else $error("ack event missing");
  a_data_low: assert property (master && $changed(d_sda_low) |-> !scl_f) else $error("data moved with clock high");
  a_baud_load: assert property (src_tick && (brg == RST_REG) && !stretch |=> brg == $past(baud))
    else $error("divider reload wrong");
  a_start_busy: assert property (start_det && !stop_det |=> busy [*2] or (busy ##1 !busy))
    else $error("busy not set");
endmodule : stw_twowire

// File: stw_slave_model.sv
// Purpose: Behavioural far-side receiver on the two-wire bus.
// Assumes: The bench resolves both lines with pull-ups.
// Notes: Acknowledges only while ack_en_i is high.
`timescale 1ns/100ps
module stw_slave_model (
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic ack_en_i,
  output logic sda_oe_o,
  output logic [7:0] byte_o,
  output int nbytes_o
);
  int bits = 0;
  logic act = 1'b0;
  logic [7:0] sh = 8'h00;
  initial begin
    sda_oe_o = 1'b0;
    byte_o = 8'h00;
    nbytes_o = 0;
  end
  ////////////////////////////////////////////////////////////////////////
  always @(negedge sda_i) begin
    if (scl_i) begin
      act = 1'b1;
      bits = 0;
    end
  end
  always @(posedge sda_i) begin
    if (scl_i) act = 1'b0;
  end
  // Eight data bits MSB first, then the acknowledge slot
  always @(posedge scl_i) begin
    if (act) begin
      if (bits < 8) sh = {sh[6:0], sda_i};
      bits++;
    end
  end
  // Release after the 9th clock so the line returns to the pull-up
  always @(negedge scl_i) begin
    if (act) begin
      if (bits == 8 && ack_en_i) sda_oe_o = 1'b1;
      if (bits == 9) begin
        sda_oe_o = 1'b0;
        bits = 0;
        byte_o = sh;
        nbytes_o++;
      end
    end
  end
endmodule : stw_slave_model

// File: serial_port_twowire_mode_tb_top.sv
// Purpose: Self-checking bench for the two-wire serial channel.
// Assumes: Master mode, f1 count source, one receiver on the bus.
// Notes: Read results are matched against notes queued by the driver.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin error_cnt++; \
  $display("[ERR] %s expected %0h seen %0h", nm, ex, got); end end
module serial_port_twowire_mode_tb_top;
  import stw_pkg::*;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [3:0] reg_addr_i = 4'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [15:0] reg_rdata_o, last_rd;
  logic scl_o, scl_oe_o, sda_o, sda_oe_o, hs_o, hs_oe_o, ev_cond_o, ev_ack_o, ev_nack_o;
  logic p_sda_oe, ack_en, rd_q;
  logic [7:0] p_byte, b;
  int p_n, n_cond, n_ack, n_nack, error_cnt, compares, seed_v;
  logic [31:0] exq[$];
  wire scl = ~scl_oe_o; // Pull-ups give the high level
  wire sda = ~(sda_oe_o | p_sda_oe);
  always #20 ref_clk_i = ~ref_clk_i;
  stw_twowire #(.FC_DIV_M1(8'h03)) i_stw_twowire (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .scl_i(scl), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .hs_o(hs_o), .hs_oe_o(hs_oe_o), .ev_cond_o(ev_cond_o),
    .ev_ack_o(ev_ack_o), .ev_nack_o(ev_nack_o));
  stw_slave_model i_stw_slave_model (.scl_i(scl), .sda_i(sda), .ack_en_i(ack_en),
    .sda_oe_o(p_sda_oe), .byte_o(p_byte), .nbytes_o(p_n));
  ////////////////////////////////////////////////////////////////////////
  // Watcher: each read result is matched against the oldest note
  always @(posedge ref_clk_i) begin
    rd_q <= reg_rd_i;
    if (ev_cond_o === 1'b1) n_cond++;
    if (ev_ack_o === 1'b1) n_ack++;
    if (ev_nack_o === 1'b1) n_nack++;
    if (rd_q === 1'b1 && exq.size() > 0) begin
      last_rd = reg_rdata_o;
      if (exq[0][15:0] != 16'h0000) `CHK("rdata", exq[0][31:16] & exq[0][15:0], reg_rdata_o & exq[0][15:0])
      void'(exq.pop_front());
    end
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  // Mask zero means a poll whose value is only kept in last_rd
  task automatic rd(input logic [3:0] a, input logic [15:0] ex, input logic [15:0] m);
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    exq.push_back({ex, m});
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    @(posedge ref_clk_i);
    #1;
  endtask : rd
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  // Bounded wait for the next acknowledge slot event
  task automatic wait_ev;
    int t0;
    t0 = n_ack + n_nack;
    for (int i = 0; i < 600 && n_ack + n_nack == t0; i++) @(posedge ref_clk_i);
    if (n_ack + n_nack == t0) begin
      error_cnt++;
      $display("[ERR] ack slot expected 1 seen 0");
      end_of_test();
    end
    repeat (10) @(posedge ref_clk_i);
  endtask : wait_ev
  initial begin
    repeat (100000) @(posedge ref_clk_i);
    error_cnt++;
    end_of_test();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    ack_en = 1'b1;
    seed_v = $urandom(32'h5e5f);
    repeat (4) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    // Reset values, unmapped index reads zero
    for (int i = 1; i < 16; i++) begin
      if (i < 10 || i == 15) rd(i[3:0], (i == 1) ? 16'h01FF : (i == 4) ? 16'h0008 : (i == 5) ? 16'h0002 : 16'h0000,
        16'hFFFF);
    end
    b = $urandom();
    wr(OFF_BAUD, b);
    wr(4'hF, 8'hA5);
    rd(OFF_BAUD, {8'h00, b}, 16'hFFFF);
    rd(4'hF, 16'h0000, 16'hFFFF);
    $display("registers done");
    // Clock and data overrides act only with the mode on; the hs pin ignores the mode
    wr(OFF_MODE, {5'h00, SMD_TWOWIRE});
    wr(OFF_SPCA, 8'h01);
    wr(OFF_SPCB, 8'h10);
    repeat (6) @(posedge ref_clk_i);
    `CHK("scl_oe", 1'b1, scl_oe_o)
    wr(OFF_SPCB, 8'h20);
    repeat (6) @(posedge ref_clk_i);
    `CHK("sda_oe", 1'b0, sda_oe_o)
    `CHK("scl_oe", 1'b0, scl_oe_o)
    wr(OFF_SPCB, 8'h02);
    wr(OFF_CTLA, 8'h10);
    wr(OFF_SPCD, 8'h07);
    repeat (3) @(posedge ref_clk_i);
    `CHK("hs", 2'b11, {hs_o, hs_oe_o})
    $display("pins done");
    // Master transfers: ack, nack, then overrun
    // Clock sync on, data delay code 3
    wr(OFF_BAUD, 8'h02);
    wr(OFF_CTLB, 8'h05);
    wr(OFF_SPCD, 8'h01);
    wr(OFF_SPCC, 8'h96);
    b = $urandom();
    wr(OFF_TXBUF, b);
    wait_ev();
    `CHK("slave byte", b, p_byte)
    `CHK("ack events", 2'h1, n_ack[1:0])
    `CHK("cond events", 2'h1, n_cond[1:0])
    rd(OFF_CTLB, 16'h0008, 16'h0008);
    rd(OFF_RXBUF, {8'h00, b}, 16'h11FF);
    ack_en = 1'b0;
    b = $urandom();
    wr(OFF_TXBUF, b);
    wait_ev();
    `CHK("nack events", 2'h1, n_nack[1:0])
    wr(OFF_TXBUF, 8'h3C);
    wait_ev();
    `CHK("slave count", 3, p_n)
    rd(OFF_RXBUF, 16'h1100, 16'h1100);
    wr(OFF_SPCC, 8'hC0);
    repeat (150) @(posedge ref_clk_i);
    `CHK("cond events", 2'h2, n_cond[1:0])
    $display("transfers done");
    // No unit without tx_on, even with the clock held low after a start
    wr(OFF_SPCC, 8'h90);
    wr(OFF_CTLB, 8'h04);
    wr(OFF_TXBUF, 8'h81);
    repeat (150) @(posedge ref_clk_i);
    `CHK("slave count", 3, p_n)
    `CHK("cond events", 2'h3, n_cond[1:0])
    rd(OFF_CTLB, 16'h0000, 16'h0002);
    rd(OFF_CTLA, 16'h0008, 16'h0008);
    $display("refusal done");
    end_of_test();
  end
endmodule : serial_port_twowire_mode_tb_top
